// >>> dv/bfs_sequencer_tb.sv
// Self-checking bench for the buck fault and power-good sequencer
module bfs_sequencer_tb;
  import bfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HC = 50;
  localparam int SC = 40;
  localparam int PC = 30;
  logic aclk = 0, aresetn = 0, en = 1, vin = 1, valley_current_limit = 0, clamp = 0, neg = 0;
  logic uv = 0, ov = 0, eov = 0, ext = 1, pwm = 0;
  logic hs, ls, hic, pg, otd, awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  int fails = 0, num_checks = 0, n;

  bfs_sequencer #(.HIC_CYCLES(HC), .SS_CYCLES(SC), .PG_CYCLES(PC)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .enable_pin(en), .vin_ok(vin),
    .ocl_cmp(valley_current_limit), .ocl_clamp_cmp(clamp), .neg_limit_cmp(neg), .uv_cmp(uv),
    .ov_cmp(ov), .early_ov_cmp(eov), .ext_ss_cmp(ext), .pwm_req(pwm),
    .on_time_done(otd), .hs_on_q(hs), .ls_on_q(ls), .hiccup_q(hic),
    .output_in_range_flag_q(pg), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  bfs_stage_model i_stage (.aclk(aclk), .hs_on_q(hs), .on_time_done(otd));

  initial forever #50 aclk = ~aclk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", s, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      k++;
    end while (!bvalid && k < 100);
    if (!bvalid) fails++;
    bready <= 1'b0;
    rs = bresp;
    @(posedge aclk);
  endtask : wr
  task automatic rd_reg(input logic [3:0] a);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      k++;
    end while (!rvalid && k < 100);
    if (!rvalid) fails++;
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    @(posedge aclk);
  endtask : rd_reg
  function automatic logic sig(input int i);
    return i == 0 ? pg : i == 1 ? hic : i == 2 ? hs : ls;
  endfunction : sig
  task automatic wt(input int i, input logic v, input int mx);
    n = 0;
    while (sig(i) !== v && n < mx) begin
      @(posedge aclk);
      n++;
    end
  endtask : wt
  task automatic hold(input string s, input int i, input logic v, input int k);
    int bad;
    bad = 0;
    repeat (k) begin
      @(posedge aclk);
      if (sig(i) !== v) bad++;
    end
    chk(s, bad, 0);
  endtask : hold
  task automatic results;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    results();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    cyc(8);
    chk("outs in reset", {hs, ls, hic, pg}, 0);
    aresetn <= 1'b1;
    wt(0, 1'b1, SC + PC + 40);
    chk("pg rise time", n >= SC + PC && n <= SC + PC + 10, 1);
    $display("test startup done");
    rd_reg(CTRL_OFS);
    chk("ctrl reset", rd, CTRL_RST);
    rd_reg(STATUS_OFS);
    chk("status run pg", rd[2:0], 3'h6);
    rd_reg(4'h8);
    chk("unmapped rd", rd, 32'h0000_0000);
    chk("unmapped resp", rs, RESP_SLVERR);
    wr(STATUS_OFS, 32'h0, 4'hF);
    chk("ro wr resp", rs, RESP_SLVERR);
    wr(CTRL_OFS, 32'h0, 4'h0);
    rd_reg(CTRL_OFS);
    chk("no strobe wr", rd, CTRL_RST);
    $display("test registers done");
    pwm <= 1'b1;
    cyc(1);
    pwm <= 1'b0;
    wt(2, 1'b1, 5);
    chk("hs start", hs, 1);
    wt(3, 1'b1, 20);
    chk("ls after on", {hs, ls}, 2'b01);
    for (int j = 0; j < 3; j++) begin
      valley_current_limit <= (j == 0);
      clamp <= (j == 1);
      eov <= (j == 2);
      cyc(4);
      pwm <= 1'b1;
      hold("pulse skipped", 2, 1'b0, 10);
      if (j < 2) chk("ls held", ls, 1);
      valley_current_limit <= 1'b0;
      clamp <= 1'b0;
      eov <= 1'b0;
      wt(2, 1'b1, 10);
      chk("pulse resumes", hs, 1);
      pwm <= 1'b0;
      wt(3, 1'b1, 20);
    end
    neg <= 1'b1;
    wt(2, 1'b1, 10);
    chk("neg hs on", {hs, ls}, 2'b10);
    neg <= 1'b0;
    wt(3, 1'b1, 20);
    chk("neg ls back", {hs, ls}, 2'b01);
    $display("test switching done");
    ov <= 1'b1;
    pwm <= 1'b1;
    cyc(12);
    chk("pg before delay", pg, 1);
    cyc(18);
    chk("pg latched", pg, 0);
    hold("hs off in ov", 2, 1'b0, 8);
    chk("ls on in ov", ls, 1);
    neg <= 1'b1;
    wt(2, 1'b1, 10);
    chk("ov discharge", {hs, ls}, 2'b10);
    neg <= 1'b0;
    ov <= 1'b0;
    pwm <= 1'b0;
    wt(3, 1'b1, 20);
    rd_reg(STATUS_OFS);
    chk("ov and pg latch", rd[4:3], 2'b11);
    hold("pg stays low", 0, 1'b0, 50);
    en <= 1'b0;
    cyc(5);
    rd_reg(STATUS_OFS);
    chk("off state", {rd[1:0], hs, ls}, 4'h0);
    en <= 1'b1;
    wt(0, 1'b1, SC + PC + 40);
    chk("pg back", n >= SC + PC && n <= SC + PC + 12, 1);
    ext <= 1'b0;
    wr(CTRL_OFS, 32'h0000_0000, 4'hF);
    rd_reg(CTRL_OFS);
    chk("ctrl cleared", rd, 32'h0000_0000);
    wr(CTRL_OFS, 32'h0000_0001, 4'hF);
    hold("pg waits ext", 0, 1'b0, SC + PC + 20);
    rd_reg(STATUS_OFS);
    chk("ext not done", {rd[5], rd[1:0]}, 3'h2);
    ext <= 1'b1;
    wt(0, 1'b1, PC + 20);
    chk("pg after ext", n >= PC && n <= PC + 8, 1);
    $display("test overvoltage done");
    uv <= 1'b1;
    cyc(400);
    uv <= 1'b0;
    cyc(10);
    uv <= 1'b1;
    cyc(400);
    uv <= 1'b0;
    chk("no hiccup", hic, 0);
    cyc(10);
    uv <= 1'b1;
    wt(1, 1'b1, 800);
    chk("uv delay", n >= 675 && n <= 690, 1);
    chk("switch off", {hs, ls}, 2'b00);
    uv <= 1'b0;
    wt(1, 1'b0, HC + 20);
    chk("hiccup length", n >= HC - 2 && n <= HC + 5, 1);
    rd_reg(STATUS_OFS);
    chk("restart ss", rd[1:0], 2'h1);
    $display("test undervoltage done");
    results();
  end
endmodule : bfs_sequencer_tb

// >>> dv/bfs_stage_model.sv
// Power-stage model that times the high-side on-time
module bfs_stage_model #(
  parameter int ON_CYC = 4
) (
  input wire logic aclk,
  input wire logic hs_on_q,
  output logic on_time_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q;
  // On-time ends a fixed count after the high side starts
  always_ff @(posedge aclk) begin
    if (!hs_on_q) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign on_time_done = hs_on_q && (cnt_q == 8'(ON_CYC));
endmodule : bfs_stage_model

// >>> src/bfs_pkg.sv
// Constants and types for the buck fault and power-good sequencer
package bfs_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_NS = 100;
  localparam int UV_DLY_NS = 68000;
  localparam int HIC_NS = 14000000;
  localparam int SS_NS = 2000000;
  localparam int PG_DLY_NS = 1060000;
  localparam int PGF_DLY_NS = 2000;
  localparam int UV_CYC = UV_DLY_NS / CLK_NS;
  localparam int HIC_CYC = HIC_NS / CLK_NS;
  localparam int SS_CYC = SS_NS / CLK_NS;
  localparam int PG_CYC = PG_DLY_NS / CLK_NS;
  localparam int PGF_CYC = PGF_DLY_NS / CLK_NS;
  localparam int TMR_W = 18;
  localparam int UVC_W = 10;
  localparam int PGFC_W = 5;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int CTRL_EN_BIT = 0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_PG_BIT = 2;
  localparam int ST_PGLATCH_BIT = 3;
  localparam int ST_OVP_BIT = 4;
  localparam int ST_EXTSS_BIT = 5;
  localparam int ST_HS_BIT = 6;
  localparam int ST_LS_BIT = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Comparator vector positions
  // ----------------------------------------
  localparam int CMP_N = 7;
  localparam int C_OCL = 0;
  localparam int C_CLAMP = 1;
  localparam int C_NEG = 2;
  localparam int C_UV = 3;
  localparam int C_OV = 4;
  localparam int C_OOB = 5;
  localparam int C_EXTSS = 6;

  typedef enum logic [1:0] {
    BFS_OFF = 2'b00,
    BFS_SS = 2'b01,
    BFS_RUN = 2'b10,
    BFS_HIC = 2'b11
  } bfs_state_e;
endpackage : bfs_pkg

// >>> src/bfs_sequencer.sv
// Fault sequencing, switch requests and power-good for a buck converter
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
module bfs_sequencer
  import bfs_pkg::*;
#(
  parameter int HIC_CYCLES = HIC_CYC,
  parameter int SS_CYCLES = SS_CYC,
  parameter int PG_CYCLES = PG_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable_pin,
  input wire logic vin_ok,
  input wire logic ocl_cmp,
  input wire logic ocl_clamp_cmp,
  input wire logic neg_limit_cmp,
  input wire logic uv_cmp,
  input wire logic ov_cmp,
  input wire logic early_ov_cmp,
  input wire logic ext_ss_cmp,
  input wire logic pwm_req,
  input wire logic on_time_done,
  output logic hs_on_q,
  output logic ls_on_q,
  output logic hiccup_q,
  output logic output_in_range_flag_q,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [TMR_W-1:0] HIC_LAST = TMR_W'(HIC_CYCLES - 1);
  localparam logic [TMR_W-1:0] SS_LAST = TMR_W'(SS_CYCLES - 1);
  localparam logic [TMR_W-1:0] PG_FULL = TMR_W'(PG_CYCLES);
  localparam logic [UVC_W-1:0] UV_LAST = UVC_W'(UV_CYC - 1);
  localparam logic [PGFC_W-1:0] PGF_LAST = PGFC_W'(PGF_CYC - 1);

  // ----------------------------------------
  // Comparator synchroniser
  // ----------------------------------------
  logic [CMP_N-1:0] cmp_meta_q;
  logic [CMP_N-1:0] cmp_q;
  wire [CMP_N-1:0] cmp_raw = {ext_ss_cmp, early_ov_cmp, ov_cmp, uv_cmp,
                              neg_limit_cmp, ocl_clamp_cmp, ocl_cmp};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_meta_q <= '0;
      cmp_q <= '0;
    end else begin
      cmp_meta_q <= cmp_raw;
      cmp_q <= cmp_meta_q;
    end
  end
  wire neg_s = cmp_q[C_NEG];
  wire uv_s = cmp_q[C_UV];
  wire ov_s = cmp_q[C_OV];
  wire ext_s = cmp_q[C_EXTSS];
  // Fixed ceiling trips even with a shorted limit-set input
  wire ocl_hold = cmp_q[C_OCL] | cmp_q[C_CLAMP];

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  logic [31:0] ctrl_q;
  bfs_state_e st_q;
  bfs_state_e st_d;
  logic [TMR_W-1:0] tmr_q;
  logic [UVC_W-1:0] uv_cnt_q;
  logic [PGFC_W-1:0] pgf_cnt_q;
  logic ext_done_q;
  logic ovp_q;
  logic pg_latch_q;
  logic phase_q;

  wire run_ok = enable_pin & vin_ok & ctrl_q[CTRL_EN_BIT];
  wire in_run = (st_q == BFS_RUN);
  wire active = (st_q == BFS_SS) | in_run;
  wire uv_limit_set_input = in_run & uv_s & (uv_cnt_q == UV_LAST);
  wire ss_end = (st_q == BFS_SS) & (tmr_q == SS_LAST);
  wire hic_end = (st_q == BFS_HIC) & (tmr_q == HIC_LAST);
  wire pg_ready = (tmr_q == PG_FULL);
  wire pgf_limit_set_input = in_run & (uv_s | ov_s) & (pgf_cnt_q == PGF_LAST);
  wire pg_latch_d = run_ok & (pg_latch_q | pgf_limit_set_input);
  wire active_n = (st_d == BFS_SS) | (st_d == BFS_RUN);

  always_comb begin
    st_d = st_q;
    if (!run_ok) begin
      st_d = BFS_OFF;
    end else begin
      case (st_q)
        BFS_OFF: st_d = BFS_SS;
        BFS_SS: if (ss_end) st_d = BFS_RUN;
        BFS_RUN: if (uv_limit_set_input) st_d = BFS_HIC;
        BFS_HIC: if (hic_end) st_d = BFS_SS;
        default: st_d = BFS_OFF;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= BFS_OFF;
      tmr_q <= '0;
    end else begin
      st_q <= st_d;
      if (st_d != st_q) begin
        tmr_q <= '0;
      end else if (!in_run || (ext_done_q && !pg_ready)) begin
        tmr_q <= tmr_q + TMR_W'(1);
      end
    end
  end

  // Undervoltage qualification, armed only in run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uv_cnt_q <= '0;
    end else if (in_run && uv_s && !uv_limit_set_input) begin
      uv_cnt_q <= uv_cnt_q + UVC_W'(1);
    end else begin
      uv_cnt_q <= '0;
    end
  end

  // Power-good fault filter and latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pgf_cnt_q <= '0;
      pg_latch_q <= 1'b0;
      ext_done_q <= 1'b0;
      output_in_range_flag_q <= 1'b0;
    end else begin
      if (in_run && (uv_s || ov_s) && !pgf_limit_set_input) begin
        pgf_cnt_q <= pgf_cnt_q + PGFC_W'(1);
      end else begin
        pgf_cnt_q <= '0;
      end
      pg_latch_q <= pg_latch_d;
      ext_done_q <= active & (ext_done_q | ext_s);
      output_in_range_flag_q <= in_run & pg_ready & !pg_latch_d;
    end
  end

  // ----------------------------------------
  // Switch requests
  // ----------------------------------------
  wire disch = ovp_q | cmp_q[C_OOB];
  wire neg_go = ls_on_q & neg_s;
  wire ocl_blk = ls_on_q & ocl_hold;
  wire hs_start = active & !phase_q & (neg_go | (pwm_req & !disch & !ov_s & !ocl_blk));
  wire hs_end = phase_q & (on_time_done | (ov_s & !ovp_q));
  wire ls_force = active & disch & !phase_q & !ls_on_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_on_q <= 1'b0;
      ls_on_q <= 1'b0;
      phase_q <= 1'b0;
      ovp_q <= 1'b0;
      hiccup_q <= 1'b0;
    end else begin
      ovp_q <= active_n & (ovp_q | (active & ov_s));
      hiccup_q <= (st_d == BFS_HIC);
      if (!active_n) begin
        hs_on_q <= 1'b0;
        ls_on_q <= 1'b0;
        phase_q <= 1'b0;
      end else if (hs_start) begin
        hs_on_q <= 1'b1;
        ls_on_q <= 1'b0;
        phase_q <= 1'b1;
      end else if (hs_end || ls_force) begin
        hs_on_q <= 1'b0;
        ls_on_q <= 1'b1;
        phase_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_got_q;
  logic w_got_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire b_hs = s_axi_bvalid & s_axi_bready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire r_hs = s_axi_rvalid & s_axi_rready;
  wire wr_go = aw_got_q & w_got_q & !s_axi_bvalid;
  wire wr_ctrl = wr_go & (aw_addr_q == CTRL_OFS);
  wire [31:0] status_w = {24'h000000, ls_on_q, hs_on_q, ext_done_q, ovp_q,
                          pg_latch_q, output_in_range_flag_q, st_q};
  wire rd_ctrl = (s_axi_araddr == CTRL_OFS);
  wire rd_stat = (s_axi_araddr == STATUS_OFS);
  wire [31:0] rd_mux = rd_ctrl ? ctrl_q : (rd_stat ? status_w : 32'h0000_0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      ctrl_q <= CTRL_RST;
    end else begin
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr;
        aw_got_q <= 1'b1;
      end else if (wr_go) begin
        aw_got_q <= 1'b0;
      end
      if (w_hs) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_got_q <= 1'b1;
      end else if (wr_go) begin
        w_got_q <= 1'b0;
      end
      s_axi_awready <= !aw_hs & !aw_got_q & !s_axi_bvalid | b_hs;
      s_axi_wready <= !w_hs & !w_got_q & !s_axi_bvalid | b_hs;
      if (wr_ctrl && w_strb_q[0]) begin
        ctrl_q <= {31'h00000000, w_data_q[CTRL_EN_BIT]};
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
      end else if (b_hs) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !ar_hs & !s_axi_rvalid | r_hs;
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= (rd_ctrl | rd_stat) ? RESP_OKAY : RESP_SLVERR;
      end else if (r_hs) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ocl_held;
    active && active_n && ls_on_q && ocl_hold && !neg_s;
  endsequence
  property p_ocl_hold;
    s_ocl_held |=> ls_on_q && !hs_on_q;
  endproperty
  a_ocl_hold: assert property (p_ocl_hold) else $error("valley hold lost");

  property p_uv_limit_set_input;
    uv_limit_set_input && run_ok |=> st_q == BFS_HIC && !hs_on_q && !ls_on_q && hiccup_q;
  endproperty
  a_uv_limit_set_input: assert property (p_uv_limit_set_input) else $error("uv shutdown missed");

  property p_hic_end;
    hic_end && run_ok |=> st_q == BFS_SS ##1 st_q != BFS_HIC;
  endproperty
  a_hic_end: assert property (p_hic_end) else $error("hiccup restart wrong");

  property p_uv_armed;
    !in_run |=> uv_cnt_q == '0;
  endproperty
  a_uv_armed: assert property (p_uv_armed) else $error("uv armed early");

  property p_uv_clear;
    in_run && !uv_s |=> uv_cnt_q == '0;
  endproperty
  a_uv_clear: assert property (p_uv_clear) else $error("uv timer kept");

  sequence s_neg_hit;
    active && active_n && neg_go && !phase_q;
  endsequence
  property p_neg_cycle;
    s_neg_hit |=> hs_on_q && !ls_on_q;
  endproperty
  a_neg_cycle: assert property (p_neg_cycle) else $error("negative cycle wrong");

  property p_disch;
    active && disch && !phase_q && !neg_go |=> !hs_on_q;
  endproperty
  a_disch: assert property (p_disch) else $error("pulse during discharge");

  property p_ovp_off;
    $rose(ovp_q) |-> !hs_on_q;
  endproperty
  a_ovp_off: assert property (p_ovp_off) else $error("high side on at ovp");

  property p_ss_len;
    ss_end && run_ok |=> in_run;
  endproperty
  a_ss_len: assert property (p_ss_len) else $error("soft-start length wrong");

  property p_pg_delay;
    $rose(output_in_range_flag_q) |-> $past(pg_ready) && $past(ext_done_q);
  endproperty
  a_pg_delay: assert property (p_pg_delay) else $error("pg rose early");

  // Consecutive out-of-range cycles, saturating at PGF_LAST, one below the filter length
  logic [PGFC_W-1:0] flt_run_q;
  wire flt_cond = in_run & run_ok & (uv_s | ov_s);
  always_ff @(posedge aclk) begin
    if (!aresetn || !flt_cond) begin
      flt_run_q <= '0;
    end else if (flt_run_q != PGF_LAST) begin
      flt_run_q <= flt_run_q + PGFC_W'(1);
    end
  end
  property p_pg_fault;
    flt_cond && (flt_run_q == PGF_LAST) |=> !output_in_range_flag_q;
  endproperty
  a_pg_fault: assert property (p_pg_fault) else $error("pg not latched low");

  property p_pg_hold;
    pg_latch_q && run_ok |=> pg_latch_q && !output_in_range_flag_q;
  endproperty
  a_pg_hold: assert property (p_pg_hold) else $error("pg latch released");

  property p_pg_run;
    output_in_range_flag_q |-> $past(in_run);
  endproperty
  a_pg_run: assert property (p_pg_run) else $error("pg outside run");
endmodule : bfs_sequencer
